// ===== testbench/tb_top.sv
/* Bench: registers over APB, ramping, ganging, emergency and zero mute.
   Assumes the source model delivers one frame every second cycle. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import vrz_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
  logic za = 0, zb = 0, cerr = 0, sfail = 0, prdy, perr, er, stb, mute;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [7:0] ga, gb;
  vrz_frame_t smp;
  int fail_count = 0, n_checks = 0, cyc = 0;
  logic [11:0] ra[6] = '{12'h0EC, 12'h0F4, 12'h0F8, 12'h0FC, 12'h100, 12'h104};
  logic [7:0] rv[6] = '{8'h00, 8'h30, 8'h30, 8'h22, 8'h00, 8'h07};
  vrz_audio_src i_vrz_audio_src (.i_clk(clk), .i_rst(rst), .i_go(go),
    .i_zero_a(za), .i_zero_b(zb), .o_stb(stb), .o_smp(smp));
  vrz_volume_zero_mute i_vrz_volume_zero_mute (.I_CLOCK(clk), .I_RESET(rst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
    .I_PWDATA(pwd), .O_PREADY(prdy), .O_PSLVERR(perr), .O_PRDATA(prd),
    .I_FRAME_STB(stb), .I_SAMPLE(smp), .I_CLK_ERROR(cerr),
    .I_SUPPLY_FAIL(sfail), .O_GAIN_A(ga), .O_GAIN_B(gb), .O_ZERO_MUTE(mute));
  initial begin
    forever #10 clk = ~clk;
  end
  task wrap_up;
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic frames(input int n);
    go <= 1;
    repeat (n) @(posedge clk iff stb);
    go <= 0;
    #1;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // Release frame first so every count starts from zero
  task automatic ztest(input logic [7:0] t, c, input logic a, b,
      input int n, input logic e);
    za <= 0;
    zb <= 0;
    frames(1);
    tick;
    `CHK("release", 1'b0, mute)
    apb(1, 12'h0EC, {24'h0, t});
    apb(1, 12'h104, {24'h0, c});
    za <= a;
    zb <= b;
    frames(n - 1);
    tick;
    `CHK("early", 1'b0, mute)
    frames(1);
    tick;
    `CHK("mute", e, mute)
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    foreach (ra[i]) begin
      apb(0, ra[i], 32'h0);
      `CHK("reset value", {24'h0, rv[i]}, rd)
    end
    apb(0, 12'h0F0, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, 12'h0F4, 32'h35);
    apb(1, 12'h0F8, 32'h2B);
    for (int k = 1; k < 5; k++) begin
      frames(1);
      `CHK("ramp b", (k > 2) ? 8'h35 : 8'(8'h30 + 2 * k), gb)
      `CHK("ramp a", (k > 2) ? 8'h2B : 8'(8'h30 - 2 * k), ga)
    end
    apb(1, 12'h0FC, 32'hFF);
    apb(1, 12'h0F8, 32'h80);
    apb(1, 12'h0F4, 32'hFF);
    frames(1);
    `CHK("direct a", 8'h80, ga)
    `CHK("mute code b", 8'hFF, gb)
    apb(1, 12'h108, 32'h1);
    frames(1);
    `CHK("a follows b", 8'hFF, ga)
    apb(1, 12'h108, 32'h2);
    frames(1);
    `CHK("a drives b", 8'h80, gb)
    apb(1, 12'h108, 32'h3);
    apb(0, 12'h108, 32'h0);
    `CHK("gang kept", 32'h2, rd)
    cerr <= 1;
    frames(2);
    `CHK("emergency a", 8'h90, ga)
    `CHK("emergency b", 8'h90, gb)
    cerr <= 0;
    sfail <= 1;
    frames(1);
    `CHK("supply fail", 8'h98, ga)
    sfail <= 0;
    apb(1, 12'h108, 32'h0);
    apb(1, 12'h0FC, 32'h49);
    apb(1, 12'h0F8, 32'hC0);
    apb(1, 12'h0F4, 32'h58);
    frames(4);
    `CHK("slow down a", 8'h9C, ga)
    `CHK("slow up b", 8'h88, gb)
    frames(4);
    `CHK("slow down a2", 8'hA0, ga)
    `CHK("slow up b2", 8'h78, gb)
    apb(1, 12'h100, 32'h6F);
    apb(0, 12'h100, 32'h0);
    `CHK("emrg fields", 32'h60, rd)
    cerr <= 1;
    frames(4);
    `CHK("emrg rate a", 8'hA4, ga)
    `CHK("emrg rate b", 8'h7C, gb)
    cerr <= 0;
    apb(0, 12'h10C, 32'h0);
    `CHK("status", 32'h0000A47C, rd)
    ztest(8'h00, 8'h03, 1, 0, 1024, 1);
    ztest(8'h00, 8'h07, 1, 0, 1024, 0);
    ztest(8'h00, 8'h07, 1, 1, 1024, 1);
    ztest(8'h00, 8'h02, 1, 0, 1024, 0);
    ztest(8'h00, 8'h01, 0, 1, 1024, 0);
    ztest(8'h01, 8'h03, 0, 1, 5120, 1);
    ztest(8'h10, 8'h03, 1, 0, 5120, 1);
    wrap_up;
  end
endmodule
bind vrz_volume_zero_mute vrz_chk i_vrz_chk (.I_CLOCK, .I_RESET, .I_PSEL,
  .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR,
  .O_PRDATA, .I_FRAME_STB, .I_SAMPLE, .I_CLK_ERROR, .I_SUPPLY_FAIL,
  .O_GAIN_A, .O_GAIN_B, .O_ZERO_MUTE);

// ===== testbench/vrz_audio_src.sv
/* Audio source model: frames on request, zero or non-zero samples.
   Assumes the bench raises i_go only while it wants frames. */
`timescale 1ns/1ns
module vrz_audio_src
  import vrz_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_zero_a,
  input wire logic i_zero_b,
  output logic o_stb,
  output vrz_frame_t o_smp
);
  logic [15:0] pat_ff;
  wire nxt_stb = i_go && !o_stb;
  // Samples keep changing between frames so stale data never looks valid
  always_ff @(posedge i_clk) begin
    o_stb <= nxt_stb && !i_rst;
    pat_ff <= i_rst ? 16'h0001 : pat_ff + 16'h0001;
    o_smp.a <= (nxt_stb && i_zero_a) ? 32'h0 : {16'hA5C3, pat_ff};
    o_smp.b <= (nxt_stb && i_zero_b) ? 32'h0 : {16'h5A3C, pat_ff};
  end
endmodule

// ===== testbench/vrz_chk.sv
/* Checker for the volume and zero-mute stage, bound to its top ports.
   Assumes a single clock domain with synchronous active-high reset. */
`timescale 1ns/1ns
`include "vrz_cfg.svh"
module vrz_chk
  import vrz_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic I_FRAME_STB,
  input wire vrz_frame_t I_SAMPLE,
  input wire logic I_CLK_ERROR,
  input wire logic I_SUPPLY_FAIL,
  input wire logic [7:0] O_GAIN_A,
  input wire logic [7:0] O_GAIN_B,
  input wire logic O_ZERO_MUTE
);
  wire [9:0] idx = I_PADDR[11:2];
  wire acc = I_PSEL && I_PENABLE;
  wire in_range = idx >= `VRZ_IDX_ZERO_THR && idx <= `VRZ_IDX_STATUS;
  wire hole = idx == `VRZ_IDX_VOL_B - 10'h001;
  wire mapped = I_PADDR[1:0] == 2'b00 && in_range && !hole;
  wire emrg = I_CLK_ERROR || I_SUPPLY_FAIL;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  sequence nz_frame;
    I_FRAME_STB && I_SAMPLE.a != 32'h0 && I_SAMPLE.b != 32'h0;
  endsequence
  reset_gain_a: assert property (disable iff (1'b0) I_RESET |=>
    O_GAIN_A == `VRZ_RST_VOL && O_GAIN_B == `VRZ_RST_VOL && !O_ZERO_MUTE)
    else $error("gain or mute wrong after reset");
  err_unmapped_a: assert property (acc |-> O_PSLVERR == !mapped)
    else $error("slave error does not match address map");
  rdata_upper_a: assert property (acc && !I_PWRITE && mapped &&
    idx != `VRZ_IDX_STATUS |-> O_PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  gain_hold_a: assert property (!I_FRAME_STB |=>
    $stable(O_GAIN_A) && $stable(O_GAIN_B))
    else $error("gain moved without a frame");
  emrg_a_dir_a: assert property (emrg && I_FRAME_STB |=>
    O_GAIN_A >= $past(O_GAIN_A))
    else $error("gain A rose during emergency");
  emrg_b_dir_a: assert property (emrg && I_FRAME_STB |=>
    O_GAIN_B >= $past(O_GAIN_B))
    else $error("gain B rose during emergency");
  mute_rel_a: assert property (nz_frame |-> ##2 !O_ZERO_MUTE)
    else $error("mute held after non-zero frame");
  mute_cause_a: assert property ($rose(O_ZERO_MUTE) |->
    $past(I_FRAME_STB, 2) &&
    ($past(I_SAMPLE.a, 2) == 32'h0 || $past(I_SAMPLE.b, 2) == 32'h0))
    else $error("mute rose without a zero frame");
endmodule

// ===== verilog/vrz_cfg.svh
/*
  Constants of the volume ramp and zero-mute stage: register indices,
  field positions, reset values and zero-detect frame counts.
  Assumes the includer works in frame (sample) units for all counts.
*/
`ifndef VRZ_CFG_SVH
`define VRZ_CFG_SVH
// Register indices; byte address is four times the index
`define VRZ_IDX_ZERO_THR 10'h03B
`define VRZ_IDX_VOL_B 10'h03D
`define VRZ_IDX_VOL_A 10'h03E
`define VRZ_IDX_RAMP 10'h03F
`define VRZ_IDX_EMRG 10'h040
`define VRZ_IDX_ZERO_CTL 10'h041
`define VRZ_IDX_GANG 10'h042
`define VRZ_IDX_STATUS 10'h043
// Reset values
`define VRZ_RST_ZERO_THR 8'h00
`define VRZ_RST_VOL 8'h30
`define VRZ_RST_RAMP 8'h22
`define VRZ_RST_EMRG 8'h00
`define VRZ_RST_ZERO_CTL 8'h07
`define VRZ_RST_GANG 2'h0
// Field positions
`define VRZ_THR_A_HI 6
`define VRZ_THR_A_LO 4
`define VRZ_THR_B_HI 2
`define VRZ_THR_B_LO 0
`define VRZ_CTL_AND_BIT 2
`define VRZ_CTL_EN_B_BIT 1
`define VRZ_CTL_EN_A_BIT 0
// Volume code that mutes completely
`define VRZ_VOL_MUTE 8'hFF
// Zero-detect thresholds in frames
`define VRZ_ZCNT_W 19
`define VRZ_ZT0 19'd1024
`define VRZ_ZT1 19'd5120
`define VRZ_ZT2 19'd10240
`define VRZ_ZT3 19'd25600
`define VRZ_ZT4 19'd51200
`define VRZ_ZT5 19'd102400
`define VRZ_ZT6 19'd256000
`define VRZ_ZT7 19'd512000
`endif

// ===== verilog/vrz_pkg.sv
/*
  Types of the volume ramp and zero-mute stage.
  Assumes vrz_cfg.svh supplies every number except the enum codes defined here.
*/
package vrz_pkg;
  typedef enum logic [1:0] {
    VRZ_RATE_1 = 2'b00,
    VRZ_RATE_2 = 2'b01,
    VRZ_RATE_4 = 2'b10,
    VRZ_RATE_DIRECT = 2'b11
  } vrz_rate_t;
  typedef enum logic [1:0] {
    VRZ_GANG_INDEP = 2'b00,
    VRZ_GANG_A_FOLLOWS_B = 2'b01,
    VRZ_GANG_A_DRIVES_BOTH = 2'b10,
    VRZ_GANG_BAD = 2'b11
  } vrz_gang_t;
  typedef struct packed {
    vrz_rate_t up_rate;
    logic [1:0] up_step;
    vrz_rate_t dn_rate;
    logic [1:0] dn_step;
  } vrz_ramp_t;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
  } vrz_frame_t;
endpackage

// ===== verilog/vrz_volume_zero_mute.sv
/*
  Per-channel digital volume with soft ramping, ganging, emergency
  ramp-down and zero-data analog mute, with an APB register slave.
  Assumes one I_FRAME_STB pulse per frame-clock period with both
  channel samples valid alongside it, all synchronous to I_CLOCK.
*/
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Zero triggers combine by OR when combine bit 0, AND when 1.
// RULE_02: Second channel enable bit gates its zero detect; default on.
// RULE_03: First channel enable bit gates its zero detect; default on.
// RULE_04: Count consecutive zero frames; mute when count reaches threshold.
// RULE_05: Threshold codes: first channel bits 6:4, second bits 2:0, reset 0.
// RULE_06: Codes 0 to 7 decode to 1024 up to 512000 frames.
// RULE_07: 8-bit volume per output; B register then A register.
// RULE_08: Gain is +24 dB minus 0.5 dB per code; 0x30 default; 0xFF mutes.
// RULE_09: Gang field: independent, A follows B, or A drives both; 11 banned.
// RULE_10: Ramp rate fields: every 1, 2, 4 frames, or direct change.
// RULE_11: Ramp step fields: 4, 2, 1 or 0.5 dB per step.
// RULE_12: Clock error or supply failure ramps down with emergency fields.
// RULE_13: Emergency default steps every frame by 4 dB.
// RULE_14: Applied gain moves toward target by step, never past it.
// RULE_15: Non-zero sample releases mute and restarts the zero count.
`include "vrz_cfg.svh"
module vrz_volume_zero_mute
  import vrz_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  input wire logic I_FRAME_STB,
  input wire vrz_frame_t I_SAMPLE,
  input wire logic I_CLK_ERROR,
  input wire logic I_SUPPLY_FAIL,
  output logic [7:0] O_GAIN_A,
  output logic [7:0] O_GAIN_B,
  output logic O_ZERO_MUTE
);

  // Step size field to volume code steps (0.5 dB per code)
  function automatic logic [7:0] step_codes(input logic [1:0] f);
    unique case (f)
      2'b00: step_codes = 8'h08;
      2'b01: step_codes = 8'h04;
      2'b10: step_codes = 8'h02;
      2'b11: step_codes = 8'h01;
    endcase
  endfunction

  // Rate field and frame phase to "step now"
  function automatic logic rate_hit(input vrz_rate_t r,
                                    input logic [1:0] ph);
    unique case (r)
      VRZ_RATE_1: rate_hit = 1'b1;
      VRZ_RATE_2: rate_hit = (ph[0] == 1'b0);
      VRZ_RATE_4: rate_hit = (ph == 2'b00);
      VRZ_RATE_DIRECT: rate_hit = 1'b1;
    endcase
  endfunction

  // All-zero sample test, shared by both channels
  function automatic logic is_silent(input logic [31:0] s);
    is_silent = (s == 32'h00000000);
  endfunction

  // Threshold code to frame count
  function automatic logic [`VRZ_ZCNT_W-1:0] zthr(input logic [2:0] c);
    unique case (c)
      3'd0: zthr = `VRZ_ZT0;
      3'd1: zthr = `VRZ_ZT1;
      3'd2: zthr = `VRZ_ZT2;
      3'd3: zthr = `VRZ_ZT3;
      3'd4: zthr = `VRZ_ZT4;
      3'd5: zthr = `VRZ_ZT5;
      3'd6: zthr = `VRZ_ZT6;
      3'd7: zthr = `VRZ_ZT7;
    endcase
  endfunction

  // One ramp move; a higher code is more attenuation
  function automatic logic [7:0] ramp_move(
    input logic [7:0] cur,
    input logic [7:0] tgt,
    input vrz_ramp_t cfg,
    input logic [1:0] ph
  );
    logic [8:0] sum;
    logic [7:0] st;
    sum = 9'h000;
    st = 8'h00;
    ramp_move = cur;
    // Near the target the last short move still waits for a rate hit
    if (tgt > cur) begin
      st = step_codes(cfg.dn_step);
      sum = {1'b0, cur} + {1'b0, st};
      if (cfg.dn_rate == VRZ_RATE_DIRECT)
        ramp_move = tgt;
      else if (rate_hit(cfg.dn_rate, ph))
        ramp_move = (sum[8] || sum[7:0] > tgt) ? tgt : sum[7:0];
    end else if (tgt < cur) begin
      st = step_codes(cfg.up_step);
      if (cfg.up_rate == VRZ_RATE_DIRECT)
        ramp_move = tgt;
      else if (rate_hit(cfg.up_rate, ph))
        ramp_move = (cur - tgt < st) ? tgt : cur - st;
    end
  endfunction

  logic [7:0] zero_thr_ff;
  logic [7:0] vol_a_ff;
  logic [7:0] vol_b_ff;
  vrz_ramp_t ramp_ff;
  logic [7:0] emrg_ff;
  logic [7:0] zero_ctl_ff;
  vrz_gang_t gang_ff;
  logic [31:0] prdata_ff;
  logic [7:0] gain_a_ff;
  logic [7:0] gain_b_ff;
  logic [1:0] phase_ff;
  logic [`VRZ_ZCNT_W-1:0] zcnt_a_ff;
  logic [`VRZ_ZCNT_W-1:0] zcnt_b_ff;
  logic zero_a_ff;
  logic zero_b_ff;
  logic mute_ff;

  // Register decode
  wire [9:0] reg_idx = I_PADDR[11:2];
  // Unaligned addresses fall into the holes of the map
  wire aligned = (I_PADDR[1:0] == 2'b00);
  wire hit_thr = aligned && reg_idx == `VRZ_IDX_ZERO_THR;
  wire hit_vb = aligned && reg_idx == `VRZ_IDX_VOL_B;
  wire hit_va = aligned && reg_idx == `VRZ_IDX_VOL_A;
  wire hit_ramp = aligned && reg_idx == `VRZ_IDX_RAMP;
  wire hit_emrg = aligned && reg_idx == `VRZ_IDX_EMRG;
  wire hit_zctl = aligned && reg_idx == `VRZ_IDX_ZERO_CTL;
  wire hit_gang = aligned && reg_idx == `VRZ_IDX_GANG;
  wire hit_stat = aligned && reg_idx == `VRZ_IDX_STATUS;
  wire mapped = hit_thr | hit_vb | hit_va | hit_ramp | hit_emrg |
                hit_zctl | hit_gang | hit_stat;
  wire setup = I_PSEL & ~I_PENABLE;
  wire access = I_PSEL & I_PENABLE;
  wire wr = access & I_PWRITE & mapped;
  // Ganging code 11 is refused so the field never holds it
  wire gang_ok = (I_PWDATA[1:0] != VRZ_GANG_BAD);

  // Status is read only; a write to it is accepted and dropped
  wire [31:0] status_word = {8'h00, 5'h00, zero_a_ff, zero_b_ff, mute_ff,
                             gain_a_ff, gain_b_ff};
  wire [31:0] rd_mux =
    hit_thr ? {24'h000000, zero_thr_ff} :
    hit_vb ? {24'h000000, vol_b_ff} :
    hit_va ? {24'h000000, vol_a_ff} :
    hit_ramp ? {24'h000000, ramp_ff} :
    hit_emrg ? {24'h000000, emrg_ff[7:4], 4'h0} :
    hit_zctl ? {24'h000000, 5'h00, zero_ctl_ff[2:0]} :
    hit_gang ? {30'h00000000, gang_ff} :
    hit_stat ? status_word : 32'h00000000;

  // Zero wait states: the answer comes in the first access cycle
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access & ~mapped;
  assign O_PRDATA = prdata_ff;

  // Captured at setup so read data stands through the access cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      prdata_ff <= 32'h00000000;
    end else if (setup) begin
      prdata_ff <= rd_mux;
    end
  end

  // RULE_05: threshold register
  // RULE_07: volume registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      zero_thr_ff <= `VRZ_RST_ZERO_THR;
      vol_a_ff <= `VRZ_RST_VOL;
      vol_b_ff <= `VRZ_RST_VOL;
      ramp_ff <= `VRZ_RST_RAMP;
      emrg_ff <= `VRZ_RST_EMRG;
      zero_ctl_ff <= `VRZ_RST_ZERO_CTL;
    end else if (wr) begin
      if (hit_thr) zero_thr_ff <= I_PWDATA[7:0] & 8'h77;
      if (hit_vb) vol_b_ff <= I_PWDATA[7:0];
      if (hit_va) vol_a_ff <= I_PWDATA[7:0];
      if (hit_ramp) ramp_ff <= I_PWDATA[7:0];
      if (hit_emrg) emrg_ff <= I_PWDATA[7:0] & 8'hF0;
      if (hit_zctl) zero_ctl_ff <= I_PWDATA[7:0] & 8'h07;
    end
  end

  // RULE_09: ganging mode, code 11 kept out
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      gang_ff <= vrz_gang_t'(`VRZ_RST_GANG);
    end else if (wr && hit_gang && gang_ok) begin
      gang_ff <= vrz_gang_t'(I_PWDATA[1:0]);
    end
  end

  // RULE_09: effective targets from ganging
  wire [7:0] tgt_a = (gang_ff == VRZ_GANG_A_FOLLOWS_B) ? vol_b_ff : vol_a_ff;
  wire [7:0] tgt_b = (gang_ff == VRZ_GANG_A_DRIVES_BOTH) ? vol_a_ff :
                     vol_b_ff;

  // RULE_12: emergency ramp toward full mute
  wire emergency = I_CLK_ERROR | I_SUPPLY_FAIL;
  // Emergency always heads for full mute, so its up fields stay unused
  // RULE_13: emergency fields reset to every frame, 4 dB
  wire [7:0] emrg_cfg_bits = {2'b00, 2'b00, emrg_ff[7:6], emrg_ff[5:4]};
  wire vrz_ramp_t emrg_cfg = vrz_ramp_t'(emrg_cfg_bits);
  wire vrz_ramp_t use_cfg = emergency ? emrg_cfg : ramp_ff;
  wire [7:0] goal_a = emergency ? `VRZ_VOL_MUTE : tgt_a;
  wire [7:0] goal_b = emergency ? `VRZ_VOL_MUTE : tgt_b;

  // RULE_10: rate interval phase
  // RULE_11: step size per move
  // RULE_14: bounded move toward target
  wire [7:0] nxt_gain_a = ramp_move(gain_a_ff, goal_a, use_cfg, phase_ff);
  wire [7:0] nxt_gain_b = ramp_move(gain_b_ff, goal_b, use_cfg, phase_ff);

  // Phase counts strobes, so slow rates step on a fixed strobe grid
  // RULE_08: applied code drives gain; 0x30 is unity at reset
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      gain_a_ff <= `VRZ_RST_VOL;
      gain_b_ff <= `VRZ_RST_VOL;
      phase_ff <= 2'h0;
    end else if (I_FRAME_STB) begin
      gain_a_ff <= nxt_gain_a;
      gain_b_ff <= nxt_gain_b;
      phase_ff <= phase_ff + 2'h1;
    end
  end

  assign O_GAIN_A = gain_a_ff;
  assign O_GAIN_B = gain_b_ff;

  // RULE_03: first channel enable
  wire en_a = zero_ctl_ff[`VRZ_CTL_EN_A_BIT];
  // RULE_02: second channel enable
  wire en_b = zero_ctl_ff[`VRZ_CTL_EN_B_BIT];
  wire and_mode = zero_ctl_ff[`VRZ_CTL_AND_BIT];
  // RULE_06: threshold decode
  wire [`VRZ_ZCNT_W-1:0] thr_a =
    zthr(zero_thr_ff[`VRZ_THR_A_HI:`VRZ_THR_A_LO]);
  wire [`VRZ_ZCNT_W-1:0] thr_b =
    zthr(zero_thr_ff[`VRZ_THR_B_HI:`VRZ_THR_B_LO]);
  wire samp_a_zero = is_silent(I_SAMPLE.a);
  wire samp_b_zero = is_silent(I_SAMPLE.b);

  // Saturating keeps the flag up through long silence without wrapping
  // RULE_04: consecutive zero frames, saturating at threshold
  // RULE_15: non-zero sample restarts count and clears flag
  wire [`VRZ_ZCNT_W-1:0] nxt_zcnt_a =
    (!en_a || !samp_a_zero) ? '0 :
    (zcnt_a_ff >= thr_a) ? zcnt_a_ff : zcnt_a_ff + 1'b1;
  wire [`VRZ_ZCNT_W-1:0] nxt_zcnt_b =
    (!en_b || !samp_b_zero) ? '0 :
    (zcnt_b_ff >= thr_b) ? zcnt_b_ff : zcnt_b_ff + 1'b1;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      zcnt_a_ff <= '0;
      zcnt_b_ff <= '0;
      zero_a_ff <= 1'b0;
      zero_b_ff <= 1'b0;
    end else if (I_FRAME_STB) begin
      zcnt_a_ff <= nxt_zcnt_a;
      zcnt_b_ff <= nxt_zcnt_b;
      zero_a_ff <= (nxt_zcnt_a >= thr_a);
      zero_b_ff <= (nxt_zcnt_b >= thr_b);
    end else begin
      // Disabling a channel drops its trigger at once
      if (!en_a) zero_a_ff <= 1'b0;
      if (!en_b) zero_b_ff <= 1'b0;
    end
  end

  // RULE_01: combine triggers; a disabled channel does not block AND
  wire mute_and = (en_a | en_b) & (~en_a | zero_a_ff) &
                  (~en_b | zero_b_ff);
  wire mute_or = (en_a & zero_a_ff) | (en_b & zero_b_ff);
  wire nxt_mute = and_mode ? mute_and : mute_or;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      mute_ff <= 1'b0;
    end else begin
      mute_ff <= nxt_mute;
    end
  end

  // Registered so a control write can never glitch the mute line
  assign O_ZERO_MUTE = mute_ff;

endmodule
